//--- rtl/fault_regs.vh
// Register offsets, field positions and codes of the program fault recorder.
// Included by every design file of the recorder; definitions only.
`ifndef FAULT_REGS_VH
`define FAULT_REGS_VH

// Register offsets (16-bit words, addressed at their own offsets)
`define ADDR_STOPPED_TASK 10'h126
`define ADDR_STOP_ADDR_LO 10'h12A
`define ADDR_STOP_ADDR_HI 10'h12B
`define ADDR_FATAL_FLAGS 10'h295
`define ADDR_STATUS 10'h296
`define ADDR_CONTROL 10'h297

// Fatal flag word bit positions
`define BIT_INSTR_FATAL 8
`define BIT_BCD_FATAL 9
`define BIT_ACCESS_FATAL 10
`define BIT_NO_END 11
`define BIT_TASK_ERR 12
`define BIT_DIFF_OVF 13
`define BIT_ILLEGAL_INSTR 14
`define BIT_UM_OVF 15

// Status word bit positions
`define BIT_INSTR_ERR 0
`define BIT_ACCESS_ERR 1
`define BIT_STOPPED 2
`define BIT_CYCLIC_IDLE 3

// Control word bit positions
`define BIT_STOP_ON_ERR 0
`define BIT_CLEAR 1
`define CONTROL_RESET 16'h0000

// Stopped-task word codes
`define TASK_NONE 16'hFFFF
`define TASK_INT_BASE 16'h8000
`define TASK_CYC_BASE 16'h0000
`define CYC_TASK_BITS 5
`define INT_TASK_BITS 8

// Stop address for a task execution error, and reset values
`define ADDR_TASK_ERR 32'hFFFFFFFF
`define ADDR_RESET 32'h00000000
`define TASK_WORD_RESET 16'h0000

// Differentiated edit limit
`define DIFF_LIMIT 18'h1FFFF

`endif

//--- rtl/task_word_encoder.v
// Encodes the running task identity into the stopped-task word.
// Assumes the task number is held stable by the recorder's task register.
`timescale 1ns/1ps
`default_nettype none
`include "fault_regs.vh"
module task_word_encoder (
  input wire cyclic_idle_i, // No cyclic task active this cycle
  input wire is_interrupt_i, // Running task is an interrupt task
  input wire [7:0] task_num_i, // Running task number
  output reg [15:0] word_o // Encoded task word
);
  // Idle beats type, since nothing could have run
  always @*
  begin
    if (cyclic_idle_i)
      word_o = `TASK_NONE;
    else if (is_interrupt_i)
      word_o = `TASK_INT_BASE | {8'h00, task_num_i[`INT_TASK_BITS-1:0]};
    else
      word_o = `TASK_CYC_BASE | {11'h000, task_num_i[`CYC_TASK_BITS-1:0]};
  end
endmodule
`default_nettype wire

//--- rtl/diff_edit_counter.v
// Counts differentiated instructions inserted or deleted during online editing.
// Assumes one pulse per edited instruction and a restart pulse per edit session.
`timescale 1ns/1ps
`default_nettype none
`include "fault_regs.vh"
module diff_edit_counter #(
  parameter WIDTH = 18,
  parameter [WIDTH-1:0] LIMIT = `DIFF_LIMIT
) (
  input wire clk_i, // System clock
  input wire reset_n_i, // Asynchronous reset, active low
  input wire restart_i, // New edit session, count from zero
  input wire edit_i, // One differentiated instruction edited
  output reg overflow_o // Count passed the limit
);
  reg [WIDTH-1:0] count;

  // Count saturates at the limit so it never wraps back under it
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count <= {WIDTH{1'b0}};
      overflow_o <= 1'b0;
    end
    else if (restart_i)
    begin
      count <= {WIDTH{1'b0}};
      overflow_o <= 1'b0;
    end
    else if (edit_i)
    begin
      if (count == LIMIT)
        overflow_o <= 1'b1;
      else
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

//--- rtl/program_fault_recorder.v
// Program fault recorder: captures task, address and cause of fatal
// program errors. Assumes the execution sequencer drives one-cycle event
// pulses synchronous to MCLK_I and halts while STOP_O is high.
`timescale 1ns/1ps
`default_nettype none
`include "fault_regs.vh"
module program_fault_recorder #(
  parameter ADDR_W = 32,
  parameter DIFF_W = 18
) (
  input wire MCLK_I, // System clock, 100 MHz
  input wire RESET_N_I, // Asynchronous reset, active low
  input wire [9:0] REG_ADDR_I, // Register address
  input wire [15:0] REG_WDATA_I, // Register write data
  input wire REG_WR_I, // Register write strobe
  input wire REG_RD_I, // Register read strobe
  output reg [15:0] REG_RDATA_O, // Read data, cycle after strobe
  input wire TASK_START_I, // Pulse: a task begins running
  input wire TASK_IS_INT_I, // Started task is an interrupt task
  input wire [7:0] TASK_NUM_I, // Started task number
  input wire CYCLIC_IDLE_I, // Level: no cyclic task active this cycle
  input wire [ADDR_W-1:0] PROG_ADDR_I, // Current program address
  input wire [ADDR_W-1:0] END_ADDR_I, // Address where end was expected
  input wire NO_END_I, // Pulse: program has no end instruction
  input wire NO_TASK_READY_I, // Pulse: no task ready in the cycle
  input wire NO_PROGRAM_I, // Pulse: task has no program allocated
  input wire NO_INT_TASK_I, // Pulse: interrupt task number absent
  input wire OPERAND_ERR_I, // Pulse: wrong operand data
  input wire INSTR_DONE_I, // Pulse: instruction completed normally
  input wire INSTR_IS_INPUT_I, // Completed instruction is an input one
  input wire PARAM_ACCESS_I, // Pulse: parameter area read or write
  input wire UNMOUNTED_WR_I, // Pulse: write to unmounted memory
  input wire FILE_MEM_WR_I, // Pulse: write to file-memory extended area
  input wire READ_ONLY_WR_I, // Pulse: write to read-only area
  input wire INDIRECT_NONBCD_I, // Pulse: non-BCD indirect value, BCD mode
  input wire EDIT_RESTART_I, // Pulse: online edit session starts
  input wire DIFF_EDIT_I, // Pulse: differentiated instruction edited
  input wire FETCH_OVER_I, // Pulse: fetch beyond program storage
  input wire ILLEGAL_INSTR_I, // Pulse: unexecutable instruction
  output wire STOP_O, // Level: CPU halted by program error
  output wire INSTR_ERR_O, // Level: instruction error flag
  output wire ACCESS_ERR_O // Level: access fault flag
);
  reg [15:0] stopped_task_word;
  reg [ADDR_W-1:0] stop_address;
  reg [15:0] fatal_flags;
  reg [15:0] control;
  reg stopped;
  reg instruction_error_flag;
  reg access_fault_flag;
  reg task_is_int;
  reg [7:0] task_num;
  reg [15:0] next_fatal_flags;
  reg next_stopped;
  reg [15:0] rdata;
  wire [15:0] task_word;
  wire diff_ovf;
  wire stop_on_err;
  wire sw_clear;
  wire any_access;
  wire task_err;
  wire fatal_now;
  wire capture;

  assign stop_on_err = control[`BIT_STOP_ON_ERR];
  assign sw_clear = REG_WR_I && (REG_ADDR_I == `ADDR_CONTROL) && REG_WDATA_I[`BIT_CLEAR];

  // Illegal access classes, the non-BCD indirect value among them
  assign any_access = PARAM_ACCESS_I | UNMOUNTED_WR_I | FILE_MEM_WR_I
    | READ_ONLY_WR_I | INDIRECT_NONBCD_I;
  // Three causes of a task execution error
  assign task_err = NO_TASK_READY_I | NO_PROGRAM_I | NO_INT_TASK_I;

  assign STOP_O = stopped;
  assign INSTR_ERR_O = instruction_error_flag;
  assign ACCESS_ERR_O = access_fault_flag;

  task_word_encoder u_task_word (
    .cyclic_idle_i(CYCLIC_IDLE_I),
    .is_interrupt_i(task_is_int),
    .task_num_i(task_num),
    .word_o(task_word)
  );

  diff_edit_counter #(
    .WIDTH(DIFF_W)
  ) u_diff_count (
    .clk_i(MCLK_I),
    .reset_n_i(RESET_N_I),
    .restart_i(EDIT_RESTART_I),
    .edit_i(DIFF_EDIT_I),
    .overflow_o(diff_ovf)
  );

  // Remember which task runs so a later stop can report it
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      task_is_int <= 1'b0;
      task_num <= 8'h00;
    end
    else if (TASK_START_I)
    begin
      task_is_int <= TASK_IS_INT_I;
      task_num <= TASK_NUM_I;
    end
  end

  // Fatal causes for this cycle; the sequencer halts on STOP_O
  always @*
  begin
    next_fatal_flags = sw_clear ? 16'h0000 : fatal_flags;
    if (NO_END_I)
      next_fatal_flags[`BIT_NO_END] = 1'b1;
    if (task_err)
      next_fatal_flags[`BIT_TASK_ERR] = 1'b1;
    if (OPERAND_ERR_I && stop_on_err)
      next_fatal_flags[`BIT_INSTR_FATAL] = 1'b1;
    if (any_access && stop_on_err)
      next_fatal_flags[`BIT_ACCESS_FATAL] = 1'b1;
    if (INDIRECT_NONBCD_I && stop_on_err)
      next_fatal_flags[`BIT_BCD_FATAL] = 1'b1;
    if (diff_ovf)
      next_fatal_flags[`BIT_DIFF_OVF] = 1'b1;
    if (FETCH_OVER_I)
      next_fatal_flags[`BIT_UM_OVF] = 1'b1;
    if (ILLEGAL_INSTR_I)
      next_fatal_flags[`BIT_ILLEGAL_INSTR] = 1'b1;
    next_stopped = |next_fatal_flags;
  end

  // In continue mode operand and access errors never reach the stop path
  assign fatal_now = NO_END_I | task_err | FETCH_OVER_I | ILLEGAL_INSTR_I
    | (diff_ovf & ~fatal_flags[`BIT_DIFF_OVF])
    | (stop_on_err & (OPERAND_ERR_I | any_access));
  // Only the first stop is captured; later events leave the record alone unless they fall in a clear cycle
  assign capture = fatal_now && (!stopped || sw_clear);

  // Fatal flags and halt; a new event in the clear cycle wins
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      fatal_flags <= 16'h0000;
      stopped <= 1'b0;
    end
    else
    begin
      fatal_flags <= next_fatal_flags;
      stopped <= next_stopped;
    end
  end

  // Capture task word and program address at the stopping point
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      stopped_task_word <= `TASK_WORD_RESET;
      stop_address <= `ADDR_RESET;
    end
    else if (capture)
    begin
      stopped_task_word <= task_word;
      if (task_err)
        stop_address <= `ADDR_TASK_ERR;
      else if (NO_END_I)
        stop_address <= END_ADDR_I;
      else
        stop_address <= PROG_ADDR_I;
    end
  end

  // Instruction error flag: set wins over a normal completion
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      instruction_error_flag <= 1'b0;
    else if (OPERAND_ERR_I)
      instruction_error_flag <= 1'b1;
    else if (INSTR_DONE_I && !INSTR_IS_INPUT_I)
      instruction_error_flag <= 1'b0;
    else if (sw_clear)
      instruction_error_flag <= 1'b0;
  end

  // Access fault flag survives task end; only software clears it
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      access_fault_flag <= 1'b0;
    else if (any_access)
      access_fault_flag <= 1'b1;
    else if (sw_clear)
      access_fault_flag <= 1'b0;
  end

  // Control register; the clear bit is a command and is not stored
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      control <= `CONTROL_RESET;
    else if (REG_WR_I && (REG_ADDR_I == `ADDR_CONTROL))
      control <= {15'h0000, REG_WDATA_I[`BIT_STOP_ON_ERR]};
  end

  // Read mux; unmapped addresses read as zero
  always @*
  begin
    case (REG_ADDR_I)
      `ADDR_STOPPED_TASK: rdata = stopped_task_word;
      `ADDR_STOP_ADDR_LO: rdata = stop_address[15:0];
      `ADDR_STOP_ADDR_HI: rdata = stop_address[31:16];
      `ADDR_FATAL_FLAGS: rdata = fatal_flags;
      `ADDR_STATUS: rdata = {12'h000, CYCLIC_IDLE_I, stopped,
        access_fault_flag, instruction_error_flag};
      `ADDR_CONTROL: rdata = control;
      default: rdata = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      REG_RDATA_O <= 16'h0000;
    else if (REG_RD_I)
      REG_RDATA_O <= rdata;
    else
      REG_RDATA_O <= 16'h0000;
  end
endmodule
`default_nettype wire

//--- verification/exec_seq_model.sv
// Sequencer model: turns bench requests into one-cycle event pulses.
// Assumes the bench raises a request bit for one clock, then drops it.
`timescale 1ns/1ps
`default_nettype none
module exec_seq_model (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [15:0] req_i, // Requested events
  output logic [15:0] ev_o // Event pulses
);
  // Masking with the last pulse keeps a held request from becoming a level
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      ev_o <= 16'h0000;
    else
      ev_o <= req_i & ~ev_o;
endmodule
`default_nettype wire

//--- verification/fault_recorder_asserts.sv
// Checker bound to the program fault recorder top ports.
// Assumes one-cycle event pulses and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module fault_recorder_asserts (
  input wire logic MCLK_I, // Clock
  input wire logic RESET_N_I, // Reset, active low
  input wire logic REG_WR_I, // Write strobe
  input wire logic NO_END_I, // Missing end
  input wire logic NO_TASK_READY_I, // No ready task
  input wire logic NO_PROGRAM_I, // No program
  input wire logic NO_INT_TASK_I, // Absent interrupt task
  input wire logic OPERAND_ERR_I, // Bad operand
  input wire logic PARAM_ACCESS_I, // Parameter access
  input wire logic UNMOUNTED_WR_I, // Unmounted write
  input wire logic FILE_MEM_WR_I, // File memory write
  input wire logic READ_ONLY_WR_I, // Read-only write
  input wire logic INDIRECT_NONBCD_I, // Non-BCD indirect
  input wire logic FETCH_OVER_I, // Fetch overrun
  input wire logic ILLEGAL_INSTR_I, // Bad instruction
  input wire logic STOP_O, // Halted
  input wire logic INSTR_ERR_O, // Instruction error
  input wire logic ACCESS_ERR_O // Access fault
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Causes grouped by fault class
  sequence s_task_cause; NO_TASK_READY_I || NO_PROGRAM_I || NO_INT_TASK_I; endsequence
  sequence s_access_cause;
    PARAM_ACCESS_I || UNMOUNTED_WR_I || FILE_MEM_WR_I || READ_ONLY_WR_I || INDIRECT_NONBCD_I;
  endsequence
  // Any bus write may be a clear, so the hold checks skip those cycles
  property p_no_end; NO_END_I |=> STOP_O; endproperty
  a_no_end: assert property (p_no_end) else $error("no stop after missing end");
  property p_task_err; s_task_cause |=> STOP_O; endproperty
  a_task_err: assert property (p_task_err) else $error("no stop on task error");
  property p_user_mem; FETCH_OVER_I |=> STOP_O; endproperty
  a_user_mem: assert property (p_user_mem) else $error("no stop on fetch overrun");
  property p_illegal; ILLEGAL_INSTR_I |=> STOP_O; endproperty
  a_illegal: assert property (p_illegal) else $error("no stop on bad instruction");
  property p_instr; OPERAND_ERR_I |=> INSTR_ERR_O; endproperty
  a_instr: assert property (p_instr) else $error("instruction error not set");
  property p_access; s_access_cause |=> ACCESS_ERR_O; endproperty
  a_access: assert property (p_access) else $error("access fault not set");
  property p_access_keep; ACCESS_ERR_O && !REG_WR_I |=> $stable(ACCESS_ERR_O); endproperty
  a_access_keep: assert property (p_access_keep) else $error("access fault lost");
  property p_stop_hold; $rose(STOP_O) ##1 !REG_WR_I |-> STOP_O; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop not held");
endmodule
`default_nettype wire

//--- verification/program_fault_recorder_test.sv
// Bench for the program fault recorder: bus tasks and stop scenarios.
// Assumes the sequencer model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fault_regs.vh"
module program_fault_recorder_test;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic is_int = 1'b0, is_in = 1'b0, idle = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [15:0] wdata = 16'h0000, req = 16'h0000;
  logic [7:0] tnum = 8'h00;
  logic [31:0] paddr = 32'h00000000, eaddr = 32'h00C0FFEE;
  wire [15:0] ev, rdata;
  wire stop, ierr, aerr;
  int bad_count = 0, compares = 0;
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  exec_seq_model i_exec_seq_model (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .ev_o(ev));
  program_fault_recorder i_program_fault_recorder (.MCLK_I(clk), .RESET_N_I(rst_n),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .TASK_START_I(ev[14]), .TASK_IS_INT_I(is_int), .TASK_NUM_I(tnum), .CYCLIC_IDLE_I(idle),
    .PROG_ADDR_I(paddr), .END_ADDR_I(eaddr), .NO_END_I(ev[0]), .NO_TASK_READY_I(ev[1]),
    .NO_PROGRAM_I(ev[2]), .NO_INT_TASK_I(ev[3]), .OPERAND_ERR_I(ev[4]),
    .INSTR_DONE_I(ev[15]), .INSTR_IS_INPUT_I(is_in), .PARAM_ACCESS_I(ev[5]),
    .UNMOUNTED_WR_I(ev[6]), .FILE_MEM_WR_I(ev[7]), .READ_ONLY_WR_I(ev[8]),
    .INDIRECT_NONBCD_I(ev[9]), .EDIT_RESTART_I(ev[13]), .DIFF_EDIT_I(ev[12]),
    .FETCH_OVER_I(ev[10]), .ILLEGAL_INSTR_I(ev[11]), .STOP_O(stop), .INSTR_ERR_O(ierr),
    .ACCESS_ERR_O(aerr));
  // Compare a 16-bit value; pins are packed as {stop, ierr, aerr}
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Write strobe for one cycle; the extra 1 ns lets the write land
  task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read strobe for one cycle; data stand only in the following cycle
  task automatic chk_reg(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // One event pulse from the sequencer, then wait until it is recorded
  task automatic fire(input int n);
    @(posedge clk);
    req <= 16'h0001 << n;
    @(posedge clk);
    req <= 16'h0000;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Start a task, stop on event n, check captured words, fire event 11 and check the record holds, clear
  task automatic stop_case(input logic i, input logic [7:0] num, input logic idl, input int n,
    input logic [15:0] tw, input logic [31:0] ad, input logic [15:0] fl);
    @(posedge clk);
    is_int <= i;
    tnum <= num;
    idle <= idl;
    paddr <= 32'h1234ABCD;
    fire(14);
    fire(n);
    chk({13'h0000, stop, ierr, aerr}, 16'h0004);
    chk_reg(`ADDR_STOPPED_TASK, tw);
    @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
    chk_reg(`ADDR_STOP_ADDR_LO, ad[15:0]);
    chk_reg(`ADDR_STOP_ADDR_HI, ad[31:16]);
    chk_reg(`ADDR_FATAL_FLAGS, fl);
    @(posedge clk);
    paddr <= 32'h00000000;
    fire(11);
    chk_reg(`ADDR_STOP_ADDR_LO, ad[15:0]);
    chk_reg(`ADDR_FATAL_FLAGS, fl | 16'h4000);
    wr_reg(`ADDR_CONTROL, 16'h0002);
    chk({13'h0000, stop, ierr, aerr}, 16'h0000);
    $display("stop case %0d done", n);
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #1000000;
    bad_count++;
    summarize;
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(`ADDR_STOPPED_TASK, 16'h5555);
    chk_reg(`ADDR_STOPPED_TASK, 16'h0000);
    chk_reg(10'h100, 16'h0000);
    stop_case(1'b0, 8'h1F, 1'b0, 11, 16'h001F, 32'h1234ABCD, 16'h4000);
    stop_case(1'b1, 8'hFF, 1'b0, 10, 16'h80FF, 32'h1234ABCD, 16'h8000);
    stop_case(1'b1, 8'h00, 1'b0, 0, 16'h8000, 32'h00C0FFEE, 16'h0800);
    stop_case(1'b0, 8'h03, 1'b1, 1, 16'hFFFF, 32'hFFFFFFFF, 16'h1000);
    stop_case(1'b0, 8'h00, 1'b0, 2, 16'h0000, 32'hFFFFFFFF, 16'h1000);
    stop_case(1'b1, 8'h07, 1'b0, 3, 16'h8007, 32'hFFFFFFFF, 16'h1000);
    fire(4);
    chk({13'h0000, stop, ierr, aerr}, 16'h0002);
    chk_reg(`ADDR_STATUS, 16'h0001);
    @(posedge clk);
    is_in <= 1'b1;
    fire(15);
    chk({13'h0000, stop, ierr, aerr}, 16'h0002);
    @(posedge clk);
    is_in <= 1'b0;
    fire(15);
    chk({13'h0000, stop, ierr, aerr}, 16'h0000);
    for (int k = 5; k < 10; k++)
    begin
      fire(k);
      fire(14);
      chk({13'h0000, stop, ierr, aerr}, 16'h0001);
      wr_reg(`ADDR_CONTROL, 16'h0002);
    end
    $display("continue mode done");
    wr_reg(`ADDR_CONTROL, 16'h0001);
    chk_reg(`ADDR_CONTROL, 16'h0001);
    fire(4);
    chk_reg(`ADDR_FATAL_FLAGS, 16'h0100);
    wr_reg(`ADDR_CONTROL, 16'h0003);
    fire(9);
    chk_reg(`ADDR_FATAL_FLAGS, 16'h0600);
    wr_reg(`ADDR_CONTROL, 16'h0003);
    fire(6);
    chk({13'h0000, stop, ierr, aerr}, 16'h0005);
    chk_reg(`ADDR_FATAL_FLAGS, 16'h0400);
    wr_reg(`ADDR_CONTROL, 16'h0002);
    fire(13);
    fire(12);
    chk_reg(`ADDR_FATAL_FLAGS, 16'h0000);
    $display("stop mode done");
    summarize;
  end
endmodule
bind program_fault_recorder fault_recorder_asserts i_fault_recorder_asserts (.MCLK_I,
  .RESET_N_I, .REG_WR_I, .NO_END_I, .NO_TASK_READY_I, .NO_PROGRAM_I, .NO_INT_TASK_I,
  .OPERAND_ERR_I, .PARAM_ACCESS_I, .UNMOUNTED_WR_I, .FILE_MEM_WR_I, .READ_ONLY_WR_I,
  .INDIRECT_NONBCD_I, .FETCH_OVER_I, .ILLEGAL_INSTR_I, .STOP_O, .INSTR_ERR_O, .ACCESS_ERR_O);
`default_nettype wire
